/* File: qecd_quad_enable_config_decode.v */
// Device-side quad-enable status decoder: serial status commands,
// quad-enable bit placement, hold pin handling and a parameter word.
// Assumes serial pins arrive asynchronously; clk is much faster than sclk.
`timescale 1ns/1ps
`include "qecd_defines.vh"

module qecd_quad_enable_config_decode (
  // Clock, reset, enable
  input wire clk,
  input wire reset,
  input wire clkEn,
  // Register port
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdData_ff,
  // Serial link pins
  input wire sclk,
  input wire chipSelN,
  input wire dataLineZero,
  input wire dataLineThree,
  output reg dataLineOneOut_ff,
  output reg dataLineOneOutEnN_ff,
  // Status towards the array logic
  output reg quadActive_ff,
  output reg dataLineThreeIsData_ff,
  output reg holdActive_ff,
  output reg quadEnable_ff
);

  // Engine states, one-hot
  localparam [3:0] ST_CMD = 4'b0001;
  localparam [3:0] ST_RD = 4'b0010;
  localparam [3:0] ST_WR = 4'b0100;
  localparam [3:0] ST_SKIP = 4'b1000;

  // Effective quad-enable bit for a given requirement code
  function qeOf;
    input [2:0] code;
    input [7:0] s1;
    input [7:0] s2;
    begin
      case (code)
        `QECD_QER_NONE: qeOf = 1'b1;
        `QECD_QER_SR1B6: qeOf = s1[6];
        `QECD_QER_SR2B7: qeOf = s2[7];
        `QECD_QER_SR2B1_CLR, `QECD_QER_SR2B1_KEEP,
        `QECD_QER_SR2B1_TWO, `QECD_QER_SR2B1_SEP: qeOf = s2[1];
        default: qeOf = 1'b0; // Reserved code never grants quad
      endcase
    end
  endfunction

  // Pin synchronisers: bit0 sclk, bit1 chipSelN, bit2 line zero, bit3 line three
  reg [3:0] syncA_ff;
  reg [3:0] syncB_ff;
  reg [3:0] syncC_ff;
  reg [3:0] pinStb_ff; // Accepted pin levels
  reg [3:0] nxt_pinStb;
  wire [3:0] pinRaw;
  assign pinRaw = {dataLineThree, dataLineZero, chipSelN, sclk};

  // Software-visible state
  reg [2:0] qerCode_ff; // Quad requirement code
  reg holdDisSup_ff; // Hold-disable capability advertised
  reg [7:0] extCfg_ff; // Extended config, bit4 keeps hold on
  reg [7:0] sr1_ff; // Status register one
  reg [7:0] sr2_ff; // Status register two

  // Serial engine state
  reg [3:0] state_ff;
  reg [2:0] bitCnt_ff; // Bit within current byte
  reg [6:0] inSh_ff; // Incoming bits, first one ends on top
  reg [7:0] outSh_ff; // Outgoing bits, bit7 leaves first
  reg [7:0] cmd_ff; // Current instruction
  reg [7:0] wrByte0_ff; // First written data byte
  reg [7:0] wrByte1_ff; // Second written data byte
  reg [1:0] wrCnt_ff; // Data bytes taken, saturates at two for WRSR, at one for the other writes

  // Derived terms
  wire [31:0] paramWord;
  wire holdEnabled;
  wire sclkRise;
  wire sclkFall;
  wire csHigh;
  wire csRise;
  wire holdNow;
  wire [7:0] byteIn;
  wire qeNow;

  // Parameter word: only the hold-disable bit and requirement code are defined
  assign paramWord = {8'h00, holdDisSup_ff, qerCode_ff, 20'h0_0000};

  // Hold stays on unless capability set and ext bit4 cleared
  assign holdEnabled = ~(holdDisSup_ff & ~extCfg_ff[`QECD_EXTCFG_HOLD]);

  // Edges counted only once second and third stages agree
  assign sclkRise = syncB_ff[0] & syncC_ff[0] & ~pinStb_ff[0];
  assign sclkFall = ~syncB_ff[0] & ~syncC_ff[0] & pinStb_ff[0];
  assign csHigh = pinStb_ff[1];
  assign csRise = syncB_ff[1] & syncC_ff[1] & ~pinStb_ff[1];

  // Line three low pauses the engine while it serves as hold
  assign holdNow = holdEnabled & ~pinStb_ff[3] & ~csHigh
                   & ~dataLineThreeIsData_ff;

  // Bit7 arrives first, so it sits at the top
  assign byteIn = {inSh_ff, pinStb_ff[2]};

  assign qeNow = qeOf(qerCode_ff, sr1_ff, sr2_ff);

  // Agreement filter for all pins
  always @* begin
    nxt_pinStb = (syncB_ff & ~(syncB_ff ^ syncC_ff)) | (pinStb_ff & (syncB_ff ^ syncC_ff));
  end

  // Three-stage synchroniser chain
  always @(posedge clk) begin
    if (reset) begin
      syncA_ff <= 4'h3;
      syncB_ff <= 4'h3;
      syncC_ff <= 4'h3;
      pinStb_ff <= 4'h3;
    end else if (clkEn) begin
      syncA_ff <= pinRaw;
      syncB_ff <= syncA_ff;
      syncC_ff <= syncB_ff;
      pinStb_ff <= nxt_pinStb;
    end
  end

  // Register port: writes and one-cycle-late read data
  always @(posedge clk) begin
    if (reset) begin
      qerCode_ff <= `QECD_RST_QER;
      holdDisSup_ff <= 1'b0;
      extCfg_ff <= `QECD_RST_EXTCFG;
      regRdData_ff <= 32'h0000_0000;
    end else if (clkEn) begin
      if (regWr) begin
        if (regAddr == `QECD_OFS_CFG) begin
          qerCode_ff <= regWrData[`QECD_CFG_QER_HI:`QECD_CFG_QER_LO];
          holdDisSup_ff <= regWrData[`QECD_CFG_HOLDDIS];
        end else if (regAddr == `QECD_OFS_EXTCFG) begin
          extCfg_ff <= regWrData[7:0];
        end
      end
      // Read data stands only in the cycle after the strobe
      if (!regRd) begin
        regRdData_ff <= 32'h0000_0000;
      end else if (regAddr == `QECD_OFS_PARAM) begin
        regRdData_ff <= paramWord;
      end else if (regAddr == `QECD_OFS_CFG) begin
        regRdData_ff <= {28'h000_0000, holdDisSup_ff, qerCode_ff};
      end else if (regAddr == `QECD_OFS_EXTCFG) begin
        regRdData_ff <= {24'h00_0000, extCfg_ff};
      end else if (regAddr == `QECD_OFS_STAT) begin
        regRdData_ff <= {15'h0000, qeNow, sr2_ff, sr1_ff};
      end else begin
        regRdData_ff <= 32'h0000_0000; // Unmapped reads as zero
      end
    end
  end

  // Serial engine: sample on rising sclk, drive on falling sclk
  always @(posedge clk) begin
    if (reset) begin
      state_ff <= ST_CMD;
      bitCnt_ff <= 3'h0;
      inSh_ff <= 7'h00;
      outSh_ff <= 8'h00;
      cmd_ff <= 8'h00;
      wrByte0_ff <= 8'h00;
      wrByte1_ff <= 8'h00;
      wrCnt_ff <= 2'h0;
      sr1_ff <= `QECD_RST_SR;
      sr2_ff <= `QECD_RST_SR;
      dataLineOneOut_ff <= 1'b0;
      dataLineOneOutEnN_ff <= 1'b1;
      quadActive_ff <= 1'b0;
      dataLineThreeIsData_ff <= 1'b0;
      holdActive_ff <= 1'b0;
      quadEnable_ff <= 1'b0;
    end else if (clkEn) begin
      holdActive_ff <= holdNow;
      quadEnable_ff <= qeNow;
      if (csRise) begin
        // Frame end commits any pending status write
        if (state_ff == ST_WR && wrCnt_ff != 2'h0) begin
          if (cmd_ff == `QECD_CMD_WRSR) begin
            sr1_ff <= wrByte0_ff;
            if (wrCnt_ff == 2'h2) begin
              sr2_ff <= wrByte1_ff;
            end else if (qerCode_ff == `QECD_QER_SR2B1_CLR) begin
              sr2_ff <= 8'h00; // One-byte write wipes status two here
            end
          end else if (cmd_ff == `QECD_CMD_WRSR2) begin
            sr2_ff <= wrByte0_ff;
          end else begin
            sr2_ff <= wrByte0_ff;
          end
        end
        state_ff <= ST_CMD;
        bitCnt_ff <= 3'h0;
        wrCnt_ff <= 2'h0;
        quadActive_ff <= 1'b0;
        dataLineThreeIsData_ff <= 1'b0;
        dataLineOneOutEnN_ff <= 1'b1;
      end else if (csHigh) begin
        // Deselected: keep engine parked
        state_ff <= ST_CMD;
        bitCnt_ff <= 3'h0;
        dataLineOneOutEnN_ff <= 1'b1;
      end else if (holdNow) begin
        // Paused by hold: ignore clock edges and release output
        dataLineOneOutEnN_ff <= 1'b1;
      end else if (sclkRise) begin
        inSh_ff <= byteIn[6:0];
        bitCnt_ff <= bitCnt_ff + 3'h1;
        if (bitCnt_ff == 3'h7) begin
          case (state_ff)
            ST_CMD: begin
              cmd_ff <= byteIn;
              if (byteIn == `QECD_CMD_RDSR1) begin
                outSh_ff <= sr1_ff;
                state_ff <= ST_RD;
              end else if (byteIn == `QECD_CMD_RDSR2 ||
                           (byteIn == `QECD_CMD_RDSR2ALT &&
                            qerCode_ff == `QECD_QER_SR2B7)) begin
                outSh_ff <= sr2_ff;
                state_ff <= ST_RD;
              end else if (byteIn == `QECD_CMD_WRSR ||
                           (byteIn == `QECD_CMD_WRSR2 &&
                            qerCode_ff == `QECD_QER_SR2B1_SEP) ||
                           (byteIn == `QECD_CMD_WRSR2ALT &&
                            qerCode_ff == `QECD_QER_SR2B7)) begin
                state_ff <= ST_WR;
              end else if (byteIn == `QECD_CMD_RD114 ||
                           byteIn == `QECD_CMD_RD144 ||
                           byteIn == `QECD_CMD_PP114) begin
                // Quad granted only with the enable bit in force
                quadActive_ff <= qeNow;
                dataLineThreeIsData_ff <= qeNow;
                state_ff <= ST_SKIP;
              end else begin
                state_ff <= ST_SKIP;
              end
            end
            ST_RD: begin
              // Repeated reads stream the same register
              if (cmd_ff == `QECD_CMD_RDSR1) begin
                outSh_ff <= sr1_ff;
              end else begin
                outSh_ff <= sr2_ff;
              end
            end
            ST_WR: begin
              if (wrCnt_ff == 2'h0) begin
                wrByte0_ff <= byteIn;
                wrCnt_ff <= 2'h1;
              end else if (wrCnt_ff == 2'h1 && cmd_ff == `QECD_CMD_WRSR) begin
                wrByte1_ff <= byteIn;
                wrCnt_ff <= 2'h2;
              end
            end
            default: begin
              state_ff <= ST_SKIP;
            end
          endcase
        end
      end else if (sclkFall && state_ff == ST_RD) begin
        // Bit7 goes out first
        dataLineOneOut_ff <= outSh_ff[7];
        dataLineOneOutEnN_ff <= 1'b0;
        outSh_ff <= {outSh_ff[6:0], 1'b0};
      end
    end
  end

endmodule // qecd_quad_enable_config_decode

/* File: qecd_defines.vh */
// Constants for the quad-enable status decoder.
// Assumes byte-addressed 32-bit register port and a single-bit serial link.
`ifndef QECD_DEFINES_VH
`define QECD_DEFINES_VH

// Register offsets (byte addresses)
`define QECD_OFS_PARAM 8'h00
`define QECD_OFS_CFG 8'h04
`define QECD_OFS_EXTCFG 8'h08
`define QECD_OFS_STAT 8'h0C

// Parameter word fields
`define QECD_PW_HOLDDIS 23
`define QECD_PW_QER_HI 22
`define QECD_PW_QER_LO 20

// Config register fields
`define QECD_CFG_QER_HI 2
`define QECD_CFG_QER_LO 0
`define QECD_CFG_HOLDDIS 3
`define QECD_EXTCFG_HOLD 4

// Reset values
`define QECD_RST_QER 3'h0
`define QECD_RST_EXTCFG 8'h10
`define QECD_RST_SR 8'h00

// Quad-enable requirement codes
`define QECD_QER_NONE 3'h0
`define QECD_QER_SR2B1_CLR 3'h1
`define QECD_QER_SR1B6 3'h2
`define QECD_QER_SR2B7 3'h3
`define QECD_QER_SR2B1_KEEP 3'h4
`define QECD_QER_SR2B1_TWO 3'h5
`define QECD_QER_SR2B1_SEP 3'h6

// Serial instructions
`define QECD_CMD_RDSR1 8'h05
`define QECD_CMD_RDSR2 8'h35
`define QECD_CMD_RDSR2ALT 8'h3F
`define QECD_CMD_WRSR 8'h01
`define QECD_CMD_WRSR2 8'h31
`define QECD_CMD_WRSR2ALT 8'h3E
`define QECD_CMD_RD114 8'h6B
`define QECD_CMD_RD144 8'hEB
`define QECD_CMD_PP114 8'h32

`endif

/* File: qecd_monitor.sv */
// Checker for the decoder's register port and serial-side flags.
// Assumes it is bound into the decoder and sees only its ports.
`timescale 1ns/1ps
`include "qecd_defines.vh"
module qecd_monitor (
  // Clock and control
  input wire clk,
  input wire reset,
  input wire clkEn,
  // Register port
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWr,
  input wire regRd,
  input wire [31:0] regRdData_ff,
  // Serial pins
  input wire sclk,
  input wire chipSelN,
  input wire dataLineZero,
  input wire dataLineThree,
  input wire dataLineOneOut_ff,
  input wire dataLineOneOutEnN_ff,
  // Flags
  input wire quadActive_ff,
  input wire dataLineThreeIsData_ff,
  input wire holdActive_ff,
  input wire quadEnable_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Frame end, then line one let go after the synchroniser delay
  sequence csEnd; $rose(chipSelN); endsequence
  sequence lineFree; ##[1:8] dataLineOneOutEnN_ff; endsequence
  a_rd_idle_zero: assert property (!$past(regRd) |-> regRdData_ff == 32'h0000_0000)
    else $error("read data outside answer cycle");
  a_param_shape: assert property (regRd && regAddr == `QECD_OFS_PARAM |=>
    regRdData_ff[31:24] == 8'h00 && regRdData_ff[19:0] == 20'h0_0000)
    else $error("parameter word has stray bits");
  a_unmapped_zero: assert property (regRd && regAddr > `QECD_OFS_STAT |=>
    regRdData_ff == 32'h0000_0000) else $error("unmapped read not zero");
  a_line_release: assert property (csEnd |-> lineFree)
    else $error("line one still driven after frame");
  a_quad_needs_qe: assert property (quadActive_ff |-> quadEnable_ff)
    else $error("quad granted without quad enable");
  a_three_data: assert property (dataLineThreeIsData_ff |-> quadActive_ff)
    else $error("line three data outside quad frame");
  a_hold_release: assert property ($rose(holdActive_ff) |-> dataLineOneOutEnN_ff [*2])
    else $error("line one driven during hold");
  a_qe_status: assert property (regRd && regAddr == `QECD_OFS_STAT && $stable(quadEnable_ff)
    |=> regRdData_ff[16] == $past(quadEnable_ff)) else $error("status enable bit differs");
  a_qe_code_none: assert property (regWr && regAddr == `QECD_OFS_CFG &&
    regWrData[2:0] == `QECD_QER_NONE |-> ##[1:3] quadEnable_ff) else $error("code none not enabled");
  a_flags_clear: assert property (chipSelN [*6] |-> !quadActive_ff)
    else $error("quad flag outlives frame");
endmodule // qecd_monitor
bind qecd_quad_enable_config_decode qecd_monitor u_qecd_monitor (.clk, .reset, .clkEn,
  .regAddr, .regWrData, .regWr, .regRd, .regRdData_ff, .sclk, .chipSelN, .dataLineZero,
  .dataLineThree, .dataLineOneOut_ff, .dataLineOneOutEnN_ff, .quadActive_ff,
  .dataLineThreeIsData_ff, .holdActive_ff, .quadEnable_ff);

/* File: qecd_host_model.sv */
// Host serial controller model: mode 0 frames, 800 ns serial clock.
// Assumes a 100 ns clk; the serial clock stands low between frames.
`timescale 1ns/1ps
module qecd_host_model (
  // Clock
  input wire clk,
  // Serial pins
  output logic sclk = 1'b0,
  output logic chipSelN = 1'b1,
  output logic dataLineZero = 1'b0,
  output logic dataLineThree = 1'b1,
  input wire dataLineOneOut_ff,
  input wire dataLineOneOutEnN_ff
);
  logic [15:0] acc;
  // Released line one shows the inverse of the last bit, not a stale value
  wire lineOne = !dataLineOneOutEnN_ff ? dataLineOneOut_ff : ~acc[0];
  // One frame: instruction, nw bytes out, nr bytes in
  task frame(input logic [7:0] cmd, input logic [15:0] wd, input int nw, input int nr,
             input logic l3, output logic [15:0] rd);
    int i;
    acc = 16'h0000;
    chipSelN <= 1'b0;
    dataLineThree <= l3;
    repeat (4) @(posedge clk);
    for (i = 0; i < 8 + 8 * (nw + nr); i++) begin
      // Data changes on the fall, bit seven first
      if (i < 8) dataLineZero <= cmd[7 - i];
      else if (i < 8 + 8 * nw) dataLineZero <= wd[23 - i];
      else dataLineZero <= ~dataLineZero;
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (3) @(posedge clk);
      if (i >= 8 + 8 * nw) acc = {acc[14:0], lineOne};
      @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    chipSelN <= 1'b1;
    dataLineThree <= 1'b1;
    // Settle gap stands in for busy polling; no busy bit exists
    repeat (10) @(posedge clk);
    rd = acc;
  endtask
endmodule // qecd_host_model

/* File: qecd_quad_enable_config_decode_tb_top.sv */
// Testbench: register port tasks plus host frames against the decoder.
// Assumes the host model and bound checker are compiled alongside.
`timescale 1ns/1ps
`include "qecd_defines.vh"
module qecd_quad_enable_config_decode_tb_top;
  logic clk = 1'b0, reset = 1'b1, clkEn = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0000_0000;
  logic [15:0] rd;
  wire [31:0] regRdData_ff;
  wire sclk, chipSelN, dataLineZero, dataLineThree, dataLineOneOut_ff, dataLineOneOutEnN_ff;
  wire quadActive_ff, dataLineThreeIsData_ff, holdActive_ff, quadEnable_ff;
  int err_count = 0, checks = 0, qCnt = 0, hCnt = 0, q0, h0;
  always #50 clk = ~clk;
  // Sticky counts of quad grant and hold cycles
  always @(posedge clk) begin
    qCnt <= qCnt + (quadActive_ff === 1'b1);
    hCnt <= hCnt + (holdActive_ff === 1'b1);
  end
  qecd_quad_enable_config_decode u_qecd_quad_enable_config_decode (.clk, .reset, .clkEn,
    .regAddr, .regWrData, .regWr, .regRd, .regRdData_ff, .sclk, .chipSelN, .dataLineZero,
    .dataLineThree, .dataLineOneOut_ff, .dataLineOneOutEnN_ff, .quadActive_ff,
    .dataLineThreeIsData_ff, .holdActive_ff, .quadEnable_ff);
  qecd_host_model u_qecd_host_model (.clk, .sclk, .chipSelN, .dataLineZero, .dataLineThree,
    .dataLineOneOut_ff, .dataLineOneOutEnN_ff);
  task cmpWord(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task cmpByte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task cmpBit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  // One-cycle write strobe
  task regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  // Read strobe, data looked at in the following cycle only
  task rdChk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    // Look mid-cycle, while the answer stands and away from the launching edge
    @(negedge clk);
    cmpWord(regRdData_ff, e);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    #2_000_000;
    err_count++;
    $display("BAD %0t run limit reached", $time);
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rdChk(`QECD_OFS_PARAM, 32'h0000_0000);
    rdChk(`QECD_OFS_EXTCFG, 32'h0000_0010);
    regWrite(`QECD_OFS_PARAM, 32'hFFFF_FFFF);
    rdChk(`QECD_OFS_PARAM, 32'h0000_0000);
    rdChk(8'h40, 32'h0000_0000);
    rdChk(`QECD_OFS_STAT, 32'h0001_0000);
    $display("test reset values done");
    regWrite(`QECD_OFS_CFG, 32'h0000_000A);
    rdChk(`QECD_OFS_PARAM, 32'h00A0_0000);
    u_qecd_host_model.frame(`QECD_CMD_WRSR, 16'hA53C, 2, 0, 1'b1, rd);
    u_qecd_host_model.frame(`QECD_CMD_RDSR1, 16'h0000, 0, 1, 1'b1, rd);
    cmpByte(rd[7:0], 8'hA5);
    u_qecd_host_model.frame(`QECD_CMD_RDSR2, 16'h0000, 0, 1, 1'b1, rd);
    cmpByte(rd[7:0], 8'h3C);
    rdChk(`QECD_OFS_STAT, 32'h0000_3CA5);
    q0 = qCnt;
    u_qecd_host_model.frame(`QECD_CMD_RD114, 16'h0000, 1, 0, 1'b1, rd);
    cmpBit(qCnt > q0, 1'b0);
    // Read-modify-write of status one to set the enable
    u_qecd_host_model.frame(`QECD_CMD_RDSR1, 16'h0000, 0, 1, 1'b1, rd);
    u_qecd_host_model.frame(`QECD_CMD_WRSR, {rd[7:0] | 8'h40, 8'h00}, 1, 0, 1'b1, rd);
    rdChk(`QECD_OFS_STAT, 32'h0001_3CE5);
    q0 = qCnt;
    u_qecd_host_model.frame(`QECD_CMD_RD114, 16'h0000, 1, 0, 1'b1, rd);
    cmpBit(qCnt > q0, 1'b1);
    $display("test status one enable done");
    regWrite(`QECD_OFS_CFG, 32'h0000_000B);
    u_qecd_host_model.frame(`QECD_CMD_WRSR2ALT, 16'h8000, 1, 0, 1'b1, rd);
    u_qecd_host_model.frame(`QECD_CMD_RDSR2ALT, 16'h0000, 0, 1, 1'b1, rd);
    cmpByte(rd[7:0], 8'h80);
    u_qecd_host_model.frame(`QECD_CMD_WRSR2, 16'h0000, 1, 0, 1'b1, rd);
    rdChk(`QECD_OFS_STAT, 32'h0001_80E5);
    regWrite(`QECD_OFS_CFG, 32'h0000_000E);
    u_qecd_host_model.frame(`QECD_CMD_WRSR2, 16'h0200, 1, 0, 1'b1, rd);
    rdChk(`QECD_OFS_STAT, 32'h0001_02E5);
    $display("test status two codes done");
    regWrite(`QECD_OFS_CFG, 32'h0000_0008);
    h0 = hCnt;
    u_qecd_host_model.frame(`QECD_CMD_RDSR1, 16'h0000, 0, 1, 1'b0, rd);
    cmpBit(hCnt > h0, 1'b1);
    q0 = qCnt;
    u_qecd_host_model.frame(`QECD_CMD_RD144, 16'h0000, 1, 0, 1'b1, rd);
    cmpBit(qCnt > q0, 1'b1);
    regWrite(`QECD_OFS_EXTCFG, 32'h0000_0000);
    rdChk(`QECD_OFS_EXTCFG, 32'h0000_0000);
    h0 = hCnt;
    u_qecd_host_model.frame(`QECD_CMD_RDSR1, 16'h0000, 0, 1, 1'b0, rd);
    cmpByte(rd[7:0], 8'hE5);
    cmpBit(hCnt > h0, 1'b0);
    $display("test hold handling done");
    // Code 001: a one-byte status write wipes status two
    regWrite(`QECD_OFS_CFG, 32'h0000_0001);
    u_qecd_host_model.frame(`QECD_CMD_WRSR, 16'h0400, 1, 0, 1'b1, rd);
    rdChk(`QECD_OFS_STAT, 32'h0000_0004);
    // Code 100: a one-byte status write leaves status two alone
    regWrite(`QECD_OFS_CFG, 32'h0000_0004);
    u_qecd_host_model.frame(`QECD_CMD_WRSR, 16'h0002, 2, 0, 1'b1, rd);
    u_qecd_host_model.frame(`QECD_CMD_WRSR, 16'h1100, 1, 0, 1'b1, rd);
    rdChk(`QECD_OFS_STAT, 32'h0001_0211);
    $display("test two-byte codes done");
    wrap_up;
  end
endmodule // qecd_quad_enable_config_decode_tb_top
